/* hdl/sdm_cfg.svh */
// Offsets, field positions, reset values and timing counts of the mode front-end.
// Assumes a 100 MHz system clock and a byte-addressed 32-bit register port.
`ifndef SDM_CFG_SVH
`define SDM_CFG_SVH
// Register offsets.
`define SDM_A_MODE 8'h00
`define SDM_A_CTRL 8'h04
`define SDM_A_STAT 8'h08
`define SDM_A_TQ_TGT 8'h0c
`define SDM_A_TQ_MAX 8'h10
`define SDM_A_NUM 8'h14
`define SDM_A_DEN 8'h18
`define SDM_A_SUBTYPE 8'h1c
`define SDM_A_POS 8'h20
`define SDM_A_PERIOD 8'h24
`define SDM_A_TIDX 8'h28
`define SDM_A_FE_WIN 8'h2c
`define SDM_A_FE_TMO 8'h30
`define SDM_A_DIN 8'h34
`define SDM_A_DOUT 8'h38
`define SDM_A_SFEN 8'h3c
`define SDM_A_POLES 8'h40
`define SDM_A_REV 8'h44
// Operating-mode codes.
`define SDM_MODE_CST 8'h0a
`define SDM_MODE_STEP 8'hff
`define SDM_MODE_SETUP 8'hfe
// Only supported time index, minus three.
`define SDM_TIDX_MS 8'hfd
// Status and control bit positions.
`define SDM_ST_SYNC 8
`define SDM_ST_INDEX 10
`define SDM_ST_FOLLOW 12
`define SDM_ST_FERR 13
`define SDM_CT_START 4
`define SDM_CT_CLOSED 0
// Reset values, level output field position and full steps per pole pair.
`define SDM_NUM_DEF 16'h0080
`define SDM_DEN_DEF 16'h0001
`define SDM_LEVEL_LSB 16
`define SDM_FULL_STEPS_PP 4
// Timing.
`define SDM_MS_NS 1000000
`define SDM_CLK_NS 10
`endif

/* hdl/sdm_pkg.sv */
// Types shared by the mode front-end.
// Assumes sdm_cfg.svh supplies the numeric constants.
package sdm_pkg;
    // One register port request, all on the system clock.
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } sdm_bus_t;
    // Auto setup sequence states, one-hot.
    typedef enum logic [2:0] {
        SDM_SU_IDLE = 3'b001,
        SDM_SU_RUN = 3'b010,
        SDM_SU_DONE = 3'b100
    } sdm_su_t;
endpackage

/* hdl/sdm_frontend.sv */
// Mode front-end: cyclic torque, step/direction pulses, auto setup, digital I/O bits.
// Assumes a 100 MHz sys_clk, a same-clock register port and fieldbus sync pulse,
// and pins (step, direction, inputs, index) that are asynchronous to sys_clk.
`include "sdm_cfg.svh"

// How it works
// - Status bit 8 shows fieldbus sync
// - Status bit 12 shows torque target used
// - Cycle is period times 1 ms only
// - Each step pulse moves one scaled step
// - Step width is numerator over denominator
// - Scaling defaults to 128 over 1
// - Four full steps per pole pair
// - Status bit 13 flags following error timeout
// - Subtype 0: step input plus direction level
// - Subtype 1: pulsing input picks direction
// - Setup starts on rising control bit 4
// - Status bit 10 shows index mark found
// - Status bit 12 set when setup done
// - Special bits low half, levels high half
// - Output n at bit 15+n, bit16 input 1
// - Limit switches stay active in these modes
module sdm_frontend #(
    parameter int NIN = 4,
    parameter int NOUT = 2,
    parameter int MS_CYC = `SDM_MS_NS / `SDM_CLK_NS
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port.
    input wire sdm_pkg::sdm_bus_t bus,
    output logic [31:0] rdata_r,
    // Fieldbus cycle and motor feedback, on sys_clk.
    input wire logic sync_pulse,
    input wire logic [31:0] act_pos,
    input wire logic setup_done,
    // Asynchronous pins.
    input wire logic step_in,
    input wire logic dir_in,
    input wire logic index_in,
    input wire logic [NIN-1:0] din,
    // Motor-side commands and outputs.
    output logic [31:0] pos_demand_r,
    output logic [15:0] torque_cmd_r,
    output logic setup_run_r,
    output logic brake_r,
    output logic [NOUT-1:0] dout_r
);
    // Pin synchronisers: first and second stage, plus previous value for edges.
    localparam int NSY = NIN + 3;
    logic [NSY-1:0] pin_raw, sy1_r, sy2_r, prev_r;
    assign pin_raw = {index_in, dir_in, step_in, din};
    // Each pin passes two flip-flops before anything reads it.
    for (genvar i = 0; i < NSY; i++) begin : g_sync
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                sy1_r[i] <= 1'b0;
                sy2_r[i] <= 1'b0;
                prev_r[i] <= 1'b0;
            end else begin
                sy1_r[i] <= pin_raw[i];
                sy2_r[i] <= sy1_r[i];
                prev_r[i] <= sy2_r[i];
            end
        end
    end

    // Synchronised levels and rising edges.
    wire [NIN-1:0] din_s = sy2_r[NIN-1:0];
    wire step_s = sy2_r[NIN];
    wire dir_s = sy2_r[NIN+1];
    wire step_rise = step_s & ~prev_r[NIN];
    wire dir_rise = dir_s & ~prev_r[NIN+1];
    wire index_rise = sy2_r[NIN+2] & ~prev_r[NIN+2];
    // Software-written registers.
    logic [7:0] mode_r, subtype_r, tidx_r, poles_r;
    logic [31:0] ctrl_r, dout_reg_r, fe_win_r;
    logic [15:0] tq_tgt_r, tq_max_r, num_r, den_r, period_r, fe_tmo_r, sfen_r;
    logic wr_seen_r;
    // Address decode.
    wire w_mode = bus.wr && bus.addr == `SDM_A_MODE;
    wire w_ctrl = bus.wr && bus.addr == `SDM_A_CTRL;
    wire w_tq = bus.wr && bus.addr == `SDM_A_TQ_TGT;
    wire w_num = bus.wr && bus.addr == `SDM_A_NUM;
    wire w_den = bus.wr && bus.addr == `SDM_A_DEN;
    wire w_tidx = bus.wr && bus.addr == `SDM_A_TIDX && bus.wdata[7:0] == `SDM_TIDX_MS;
    // Mode decode; the master selects the mode by code.
    wire m_cst = mode_r == `SDM_MODE_CST;
    wire m_step = mode_r == `SDM_MODE_STEP;
    wire m_setup = mode_r == `SDM_MODE_SETUP;
    // Register writes; unmapped addresses are ignored.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= 8'h00;
            ctrl_r <= 32'h0;
            tq_tgt_r <= 16'h0;
            tq_max_r <= 16'h0;
            num_r <= `SDM_NUM_DEF;
            den_r <= `SDM_DEN_DEF;
            subtype_r <= 8'h00;
            period_r <= 16'h0001;
            tidx_r <= `SDM_TIDX_MS;
            fe_win_r <= 32'h0;
            fe_tmo_r <= 16'h0;
            dout_reg_r <= 32'h0;
            sfen_r <= 16'h0;
            poles_r <= 8'h01;
            wr_seen_r <= 1'b0;
        end else begin
            wr_seen_r <= wr_seen_r | w_num | w_den;
            if (w_mode) mode_r <= bus.wdata[7:0];
            if (w_ctrl) ctrl_r <= bus.wdata;
            if (w_tq) tq_tgt_r <= bus.wdata[15:0];
            if (bus.wr && bus.addr == `SDM_A_TQ_MAX) tq_max_r <= bus.wdata[15:0];
            if (w_num) num_r <= bus.wdata[15:0];
            if (w_den) den_r <= bus.wdata[15:0];
            if (bus.wr && bus.addr == `SDM_A_SUBTYPE) subtype_r <= bus.wdata[7:0];
            if (bus.wr && bus.addr == `SDM_A_PERIOD) period_r <= bus.wdata[15:0];
            if (w_tidx) tidx_r <= bus.wdata[7:0];
            if (bus.wr && bus.addr == `SDM_A_FE_WIN) fe_win_r <= bus.wdata;
            if (bus.wr && bus.addr == `SDM_A_FE_TMO) fe_tmo_r <= bus.wdata[15:0];
            if (bus.wr && bus.addr == `SDM_A_DOUT) dout_reg_r <= bus.wdata;
            if (bus.wr && bus.addr == `SDM_A_SFEN) sfen_r <= bus.wdata[15:0];
            if (bus.wr && bus.addr == `SDM_A_POLES) poles_r <= bus.wdata[7:0];
        end
    end

    // Millisecond time base for the cycle and following-error timers.
    logic [$clog2(MS_CYC)-1:0] ms_cnt_r;
    wire ms_tick = ms_cnt_r == ($clog2(MS_CYC))'(MS_CYC - 1);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) ms_cnt_r <= '0;
        else ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
    end
    // Cycle supervision: in sync when pulses are one period apart, closing-edge tick counted.
    logic [15:0] since_r;
    logic sync_ok_r, fresh_r, follow_r;
    wire late = since_r > period_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            since_r <= 16'h0;
            sync_ok_r <= 1'b0;
            fresh_r <= 1'b0;
            follow_r <= 1'b0;
        end else begin
            if (sync_pulse) since_r <= 16'h0;
            else if (ms_tick && !late) since_r <= since_r + 16'h1;
            if (sync_pulse) sync_ok_r <= since_r + 16'(ms_tick) == period_r;
            else if (late) sync_ok_r <= 1'b0;
            // A target write in the sync cycle counts for the next cycle.
            if (w_tq) fresh_r <= 1'b1;
            else if (sync_pulse) fresh_r <= 1'b0;
            // The target is followed only while in sync and refreshed each cycle.
            if (sync_pulse) follow_r <= (since_r + 16'(ms_tick) == period_r) && fresh_r;
            else if (late) follow_r <= 1'b0;
        end
    end

    // Limit switches, gated by their special-function enables.
    wire lim_neg = din_s[0] & sfen_r[0];
    wire lim_pos = din_s[1] & sfen_r[1];
    // Torque command: target clamped to the maximum, blocked toward a hit limit.
    wire signed [15:0] tq_s = tq_tgt_r;
    wire signed [16:0] tq_max_s = {1'b0, tq_max_r};
    wire tq_hi = 17'(tq_s) > tq_max_s;
    wire tq_lo = 17'(tq_s) < -tq_max_s;
    wire tq_block = (lim_neg && tq_s < 0) || (lim_pos && tq_s > 0);
    wire [15:0] tq_clamp = tq_hi ? tq_max_r : tq_lo ? 16'(-tq_max_s) : tq_tgt_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) torque_cmd_r <= 16'h0;
        else torque_cmd_r <= (m_cst && follow_r && !tq_block) ? tq_clamp : 16'h0;
    end

    // Step width divider: restarts after each scaling write, 17 cycles (one load, 16 shift steps).
    logic [15:0] width_r, quo_r;
    logic [16:0] rem_r;
    logic [4:0] div_cnt_r;
    wire div_busy = div_cnt_r != 5'd0;
    wire [16:0] rem_sh = {rem_r[15:0], quo_r[15]};
    wire rem_ge = rem_sh >= {1'b0, den_r};
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            width_r <= `SDM_NUM_DEF;
            quo_r <= 16'h0;
            rem_r <= 17'h0;
            div_cnt_r <= 5'd0;
        end else if (w_num || w_den) begin
            div_cnt_r <= 5'd17;
        end else if (div_cnt_r == 5'd17) begin
            quo_r <= num_r;
            rem_r <= 17'h0;
            div_cnt_r <= 5'd16;
        end else if (div_busy) begin
            rem_r <= rem_ge ? rem_sh - {1'b0, den_r} : rem_sh;
            quo_r <= {quo_r[14:0], rem_ge};
            div_cnt_r <= div_cnt_r - 5'd1;
            if (div_cnt_r == 5'd1) width_r <= (den_r == 16'h0) ? 16'h0 : {quo_r[14:0], rem_ge};
        end
    end

    // Step decode per subtype: up and down requests.
    wire sub_dual = subtype_r == 8'h01;
    wire up_req = sub_dual ? (step_rise && !dir_rise) : (step_rise && !dir_s);
    wire dn_req = sub_dual ? (dir_rise && !step_rise) : (step_rise && dir_s);
    wire step_up = m_step && up_req && !lim_pos;
    wire step_dn = m_step && dn_req && !lim_neg;
    wire [31:0] width_x = {16'h0, width_r};
    // Position demand, one scaled step per accepted pulse.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) pos_demand_r <= 32'h0;
        else if (step_up) pos_demand_r <= pos_demand_r + width_x;
        else if (step_dn) pos_demand_r <= pos_demand_r - width_x;
    end
    // Full steps per revolution for a brushless motor handled as a stepper.
    wire [15:0] rev_steps = 16'(poles_r) * 16'(`SDM_FULL_STEPS_PP);
    // Following error: out of window for longer than the timeout in closed loop.
    wire [31:0] fe_diff = pos_demand_r - act_pos;
    wire [31:0] fe_abs = fe_diff[31] ? -fe_diff : fe_diff;
    wire fe_out = m_step && ctrl_r[`SDM_CT_CLOSED] && fe_abs > fe_win_r;
    logic [15:0] fe_ms_r;
    logic fe_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fe_ms_r <= 16'h0;
            fe_r <= 1'b0;
        end else begin
            if (!fe_out) fe_ms_r <= 16'h0;
            else if (ms_tick && fe_ms_r != 16'hffff) fe_ms_r <= fe_ms_r + 16'h1;
            fe_r <= fe_out && fe_ms_r > fe_tmo_r;
        end
    end

    // Auto setup sequence, started only on a rising start bit.
    sdm_pkg::sdm_su_t su_r, su_nxt;
    logic start_prev_r, indexed_r, aligned_r;
    wire start_rise = ctrl_r[`SDM_CT_START] && !start_prev_r;
    wire su_go = m_setup && start_rise && !lim_neg && !lim_pos;
    always_comb begin
        su_nxt = su_r;
        unique case (su_r)
            sdm_pkg::SDM_SU_IDLE: if (su_go) su_nxt = sdm_pkg::SDM_SU_RUN;
            sdm_pkg::SDM_SU_RUN: begin
                if (!m_setup) su_nxt = sdm_pkg::SDM_SU_IDLE;
                else if (setup_done) su_nxt = sdm_pkg::SDM_SU_DONE;
            end
            sdm_pkg::SDM_SU_DONE: if (su_go) su_nxt = sdm_pkg::SDM_SU_RUN;
            default: su_nxt = sdm_pkg::SDM_SU_IDLE;
        endcase
    end

    // Setup state, index flag and completion flag.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            su_r <= sdm_pkg::SDM_SU_IDLE;
            start_prev_r <= 1'b0;
            indexed_r <= 1'b0;
            aligned_r <= 1'b0;
            setup_run_r <= 1'b0;
        end else begin
            su_r <= su_nxt;
            start_prev_r <= ctrl_r[`SDM_CT_START];
            setup_run_r <= su_nxt == sdm_pkg::SDM_SU_RUN;
            // A new run clears the index flag; an index edge in the run sets it.
            if (su_r == sdm_pkg::SDM_SU_RUN && index_rise) indexed_r <= 1'b1;
            else if (su_go) indexed_r <= 1'b0;
            if (su_r == sdm_pkg::SDM_SU_RUN && setup_done) aligned_r <= 1'b1;
            else if (su_go) aligned_r <= 1'b0;
        end
    end

    // Status word assembled per mode.
    wire [31:0] stat_w = {18'h0,
        m_step & fe_r,
        (m_cst & follow_r) | (m_setup & aligned_r),
        1'b0,
        m_setup & indexed_r,
        1'b0,
        m_cst & sync_ok_r,
        8'h0};
    // Digital inputs: special bits low, levels from bit 16 regardless of enable.
    wire [15:0] din_lvl = 16'(din_s);
    wire [15:0] din_sf = din_lvl & sfen_r;
    wire [31:0] din_w = {din_lvl, din_sf};
    // Brake and level outputs, output n taken from bit 15+n.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            brake_r <= 1'b0;
            dout_r <= '0;
        end else begin
            brake_r <= dout_reg_r[0];
            dout_r <= dout_reg_r[`SDM_LEVEL_LSB +: NOUT];
        end
    end

    // Read multiplexer; unmapped addresses read zero.
    logic [31:0] rd_mux;
    always_comb begin
        unique case (bus.addr)
            `SDM_A_MODE: rd_mux = {24'h0, mode_r};
            `SDM_A_CTRL: rd_mux = ctrl_r;
            `SDM_A_STAT: rd_mux = stat_w;
            `SDM_A_TQ_TGT: rd_mux = {16'h0, tq_tgt_r};
            `SDM_A_TQ_MAX: rd_mux = {16'h0, tq_max_r};
            `SDM_A_NUM: rd_mux = {16'h0, num_r};
            `SDM_A_DEN: rd_mux = {16'h0, den_r};
            `SDM_A_SUBTYPE: rd_mux = {24'h0, subtype_r};
            `SDM_A_POS: rd_mux = pos_demand_r;
            `SDM_A_PERIOD: rd_mux = {16'h0, period_r};
            `SDM_A_TIDX: rd_mux = {24'h0, tidx_r};
            `SDM_A_FE_WIN: rd_mux = fe_win_r;
            `SDM_A_FE_TMO: rd_mux = {16'h0, fe_tmo_r};
            `SDM_A_DIN: rd_mux = din_w;
            `SDM_A_DOUT: rd_mux = dout_reg_r;
            `SDM_A_SFEN: rd_mux = {16'h0, sfen_r};
            `SDM_A_POLES: rd_mux = {24'h0, poles_r};
            `SDM_A_REV: rd_mux = {16'h0, rev_steps};
            default: rd_mux = 32'h0;
        endcase
    end
    // Read data stand one cycle after the read strobe, zero otherwise.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) rdata_r <= 32'h0;
        else rdata_r <= bus.rd ? rd_mux : 32'h0;
    end
    // Checks.
    sync_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        bus.rd && bus.addr == `SDM_A_STAT && m_cst |=> rdata_r[8] == $past(sync_ok_r))
        else $error("sync status bit wrong");
    follow_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        m_cst && !follow_r |=> torque_cmd_r == 16'h0)
        else $error("torque applied while not following");
    step_adv_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        step_up |=> pos_demand_r == $past(pos_demand_r) + $past(width_x))
        else $error("step did not advance by width");
    div_res_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(div_busy) && den_r != 16'h0 |-> 32'(width_r) * 32'(den_r) <= 32'(num_r))
        else $error("step width too large");
    scale_def_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !wr_seen_r |-> width_r == `SDM_NUM_DEF && num_r == `SDM_NUM_DEF)
        else $error("default scaling lost");
    dual_dir_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        m_step && sub_dual && dir_rise && !step_rise && !lim_neg
        |=> pos_demand_r == $past(pos_demand_r) - $past(width_x))
        else $error("second input did not step down");
    setup_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(setup_run_r) |-> $past(su_go))
        else $error("setup started without rising start bit");
    index_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        su_r == sdm_pkg::SDM_SU_RUN && index_rise |=> indexed_r)
        else $error("index mark not recorded");
    aligned_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        su_r == sdm_pkg::SDM_SU_RUN && setup_done |=> aligned_r ##1 !setup_run_r)
        else $error("setup completion not flagged");
    ferr_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fe_r |-> $past(fe_out) && $past(fe_ms_r) > $past(fe_tmo_r))
        else $error("following error without timeout");
    level_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        bus.rd && bus.addr == `SDM_A_DIN |=> rdata_r[16] == $past(din_s[0]))
        else $error("input 1 level bit wrong");
    limit_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        lim_neg && !step_up |=> pos_demand_r == $past(pos_demand_r))
        else $error("moved into negative limit");
endmodule

/* testbench/sdm_ctl_model.sv */
// Behavioural positioning controller that drives the step and direction pins.
// Assumes the bench calls send() and waits for it; pins stand still between bursts.
module sdm_ctl_model (
    // Pins towards the front-end.
    output logic step_in,
    output logic dir_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Both pins rest low until the first burst.
    initial begin
        step_in = 1'b0;
        dir_in = 1'b0;
    end

    // Sends n pulses; neg picks the direction, dual picks the two-input subtype.
    task automatic send(input int n, input bit neg, input bit dual);
        logic lvl;
        // The phase offset keeps pin edges unrelated to the system clock.
        #37;
        lvl = dual ? 1'b0 : neg;
        // A direction change is followed by the settling pause.
        if (dir_in !== lvl) begin
            dir_in = lvl;
            #35000;
        end
        // Each pulse is three link ticks high and ten low, a 1040 ns period, just under 1 MHz.
        for (int i = 0; i < n; i++) begin
            if (dual && neg) begin
                dir_in = 1'b1;
            end else begin
                step_in = 1'b1;
            end
            #240;
            step_in = 1'b0;
            if (dual) begin
                dir_in = 1'b0;
            end
            #800;
        end
    endtask
endmodule

/* testbench/step_dir_and_mode_frontend_test.sv */
// Self-checking bench of the mode front-end, with random step bursts.
// Assumes the register port answers one cycle after the read strobe.
`include "sdm_cfg.svh"

module step_dir_and_mode_frontend_test;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock, reset and same-clock inputs.
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sync_pulse = 1'b0;
    logic setup_done = 1'b0;
    logic index_in = 1'b0;
    logic [31:0] act_pos = 32'h0;
    logic [3:0] din = 4'h0;
    sdm_pkg::sdm_bus_t bus = '0;
    // Design outputs.
    logic [31:0] rdata_r;
    logic [31:0] pos_demand_r;
    logic [15:0] torque_cmd_r;
    logic setup_run_r;
    logic brake_r;
    logic [1:0] dout_r;
    wire step_in;
    wire dir_in;
    // Bookkeeping.
    int bad_count = 0;
    int compares = 0;
    int cyc = 0;
    logic [31:0] v;
    logic [31:0] t;

    // The 100 MHz system clock.
    always #5 sys_clk = ~sys_clk;

    sdm_frontend #(.MS_CYC(10)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rdata_r(rdata_r),
        .sync_pulse(sync_pulse), .act_pos(act_pos), .setup_done(setup_done),
        .step_in(step_in), .dir_in(dir_in), .index_in(index_in), .din(din),
        .pos_demand_r(pos_demand_r), .torque_cmd_r(torque_cmd_r),
        .setup_run_r(setup_run_r), .brake_r(brake_r), .dout_r(dout_r)
    );

    sdm_ctl_model u_ctl (.step_in(step_in), .dir_in(dir_in));

    // Counts, prints the verdict and ends the run.
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // A hang is cut short well after the expected run length.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            bad_count++;
            print_verdict();
        end
    end

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask

    // One-cycle register read; the data are taken in the following cycle.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        @(posedge sys_clk);
        d = rdata_r;
    endtask

    // Position expected after n steps of width w.
    function automatic logic [31:0] step_exp(logic [31:0] p, int n, bit neg, logic [31:0] w);
        return neg ? p - n * w : p + n * w;
    endfunction

    // Sends a burst and checks the move; gate low means it must be ignored.
    task automatic steps(input int n, input bit neg, input bit dual, input logic [31:0] w,
                         input bit gate);
        logic [31:0] p0;
        p0 = pos_demand_r;
        u_ctl.send(n, neg, dual);
        repeat (10) @(posedge sys_clk);
        chk("pos_demand_r", gate ? step_exp(p0, n, neg, w) : p0, pos_demand_r);
    endtask

    // One fieldbus sync pulse.
    task automatic sync1();
        @(posedge sys_clk);
        sync_pulse <= 1'b1;
        @(posedge sys_clk);
        sync_pulse <= 1'b0;
    endtask

    // Main sequence.
    initial begin
        void'($urandom(32'hc2fc));
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Reset values, read-only derived count and refused writes.
        rd(`SDM_A_NUM, v); chk("num", `SDM_NUM_DEF, v);
        rd(`SDM_A_DEN, v); chk("den", `SDM_DEN_DEF, v);
        wr(`SDM_A_TIDX, 32'h1);
        rd(`SDM_A_TIDX, v); chk("tidx", 32'hfd, v);
        rd(`SDM_A_REV, v); chk("rev", 32'h4, v);
        wr(`SDM_A_POLES, 32'h3);
        rd(`SDM_A_REV, v); chk("rev", 32'hc, v);
        rd(8'hfc, v); chk("unmapped", 32'h0, v);
        $display("test registers done");
        // Plain pulse plus direction, default width, then 512 over 2.
        wr(`SDM_A_MODE, 32'hff);
        for (int k = 0; k < 4; k++) begin
            steps(1 + $urandom % 4, $urandom % 2, 1'b0, 32'h80, 1'b1);
        end
        wr(`SDM_A_NUM, 32'h200);
        wr(`SDM_A_DEN, 32'h2);
        repeat (20) @(posedge sys_clk);
        steps(2, 1'b0, 1'b0, 32'h100, 1'b1);
        // Two-input subtype, both directions.
        wr(`SDM_A_SUBTYPE, 32'h1);
        steps(1 + $urandom % 3, 1'b0, 1'b1, 32'h100, 1'b1);
        steps(1 + $urandom % 3, 1'b1, 1'b1, 32'h100, 1'b1);
        wr(`SDM_A_SUBTYPE, 32'h0);
        // An enabled negative limit blocks only the negative direction.
        din <= 4'h1;
        wr(`SDM_A_SFEN, 32'h1);
        steps(1, 1'b1, 1'b0, 32'h100, 1'b0);
        steps(1, 1'b0, 1'b0, 32'h100, 1'b1);
        // Levels of the inputs, with and without special functions.
        for (int s = 0; s < 2; s++) begin
            wr(`SDM_A_SFEN, s);
            din <= 4'($urandom);
            repeat (5) @(posedge sys_clk);
            rd(`SDM_A_DIN, v); chk("din levels", {28'h0, din}, {28'h0, v[19:16]});
            chk("din special", {28'h0, din & 4'(s)}, {28'h0, v[3:0]});
        end
        din <= 4'h0;
        t = {14'h0, 2'($urandom), 16'h1};
        wr(`SDM_A_DOUT, t);
        repeat (2) @(posedge sys_clk);
        chk("dout_r", {30'h0, t[17:16]}, {30'h0, dout_r});
        chk("brake_r", 32'h1, {31'h0, brake_r});
        $display("test step mode done");
        // Following error in closed loop.
        act_pos <= pos_demand_r;
        wr(`SDM_A_FE_WIN, 32'h4);
        wr(`SDM_A_FE_TMO, 32'h1);
        wr(`SDM_A_CTRL, 32'h1);
        repeat (30) @(posedge sys_clk);
        rd(`SDM_A_STAT, v); chk("ferr", 32'h0, v & 32'h2000);
        act_pos <= pos_demand_r + 32'h64;
        repeat (40) @(posedge sys_clk);
        rd(`SDM_A_STAT, v); chk("ferr", 32'h2000, v & 32'h2000);
        wr(`SDM_A_CTRL, 32'h0);
        $display("test following error done");
        // Cyclic torque: two syncs exactly one period apart.
        wr(`SDM_A_TQ_MAX, 32'h1000);
        wr(`SDM_A_MODE, 32'h0a);
        steps(1, 1'b0, 1'b0, 32'h100, 1'b0);
        t = $urandom % 32'h1000;
        wr(`SDM_A_TQ_TGT, t);
        sync1();
        wr(`SDM_A_TQ_TGT, t);
        repeat (6) @(posedge sys_clk);
        sync1();
        rd(`SDM_A_STAT, v); chk("cst stat", 32'h1100, v & 32'h3500);
        chk("torque_cmd_r", t & 32'hffff, {16'h0, torque_cmd_r});
        repeat (30) @(posedge sys_clk);
        rd(`SDM_A_STAT, v); chk("cst overrun", 32'h0, v & 32'h3500);
        chk("torque_cmd_r", 32'h0, {16'h0, torque_cmd_r});
        $display("test torque done");
        // Auto setup: start on a rising start bit, index and aligned flags.
        wr(`SDM_A_MODE, 32'hfe);
        wr(`SDM_A_CTRL, 32'h10);
        repeat (3) @(posedge sys_clk);
        chk("setup_run_r", 32'h1, {31'h0, setup_run_r});
        index_in <= 1'b1;
        repeat (6) @(posedge sys_clk);
        index_in <= 1'b0;
        rd(`SDM_A_STAT, v); chk("indexed", 32'h400, v & 32'h400);
        setup_done <= 1'b1;
        @(posedge sys_clk);
        setup_done <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("setup_run_r", 32'h0, {31'h0, setup_run_r});
        rd(`SDM_A_STAT, v); chk("aligned", 32'h1000, v & 32'h1000);
        wr(`SDM_A_CTRL, 32'h10);
        repeat (3) @(posedge sys_clk);
        chk("setup_run_r", 32'h0, {31'h0, setup_run_r});
        $display("test auto setup done");
        print_verdict();
    end
endmodule
